// ==== strap_cfg_pkg.sv ====
// Purpose: Shared constants for the strap configuration loader.
// Assumes: Eight-bit register images as seen by the serial register path.
// Notes:   Offsets index the register image array.
package strap_cfg_pkg;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [2:0] OFF_HS_MODES   = 3'h0;
  localparam logic [2:0] OFF_AUX_MODES  = 3'h1;
  localparam logic [2:0] OFF_RX_SET     = 3'h2;
  localparam logic [2:0] OFF_TERM_PUL1  = 3'h3;
  localparam logic [2:0] OFF_TERM_PUL2  = 3'h4;
  localparam logic [2:0] OFF_EQ1        = 3'h5;
  localparam logic [2:0] OFF_EQ2        = 3'h6;
  localparam logic [2:0] OFF_TX_SET     = 3'h7;
  localparam int unsigned POS_SW_ENABLE = 6;
  localparam int unsigned POS_MODE_LO   = 4;
  localparam int unsigned POS_SRC_LO    = 0;
  localparam int unsigned POS_PE_LO     = 2;
  localparam int unsigned POS_OTO       = 1;
  localparam int unsigned POS_OCL       = 0;
  localparam logic [1:0] MODE_QUAD      = 2'h0;
  localparam logic [7:0] RST_HS_MODES   = 8'h00;
  localparam logic [7:0] RST_AUX_MODES  = 8'h40;
  localparam logic [7:0] RST_RX_SET     = 8'h01;
  localparam logic [7:0] RST_TERM_PUL   = 8'h00;
  localparam logic [7:0] RST_EQ         = 8'h00;
  localparam logic [7:0] RST_TX_SET     = 8'h00;
  typedef enum logic [0:0] {
    SRC_STRAP  = 1'b0,
    SRC_SERIAL = 1'b1
  } cfg_src_type;
endpackage

// ==== strap_sync.sv ====
// Purpose: Two-stage synchroniser for a bus of static strap levels.
// Assumes: Straps are asynchronous board levels.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
module strap_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// ==== cfg_image_mem.sv ====
// Purpose: Small register image memory with registered read data.
// Assumes: One write and one read port on one clock.
// Notes:   Holds only the bytes written through the register port, never the strap values.
`timescale 1ns/1ps
module cfg_image_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rd_data_r;
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= mem_r[rd_addr];
    end
  end
  assign rd_data = rd_data_r;
endmodule

// ==== pin_strap_switch_config.sv ====
// Summary of operation
// - Strap mode fixes high-speed switching to quad.
// - Enable strap low is standby, high on.
// - Source strap 00..11 routes source A..D.
// - Auxiliary switch held enabled, quad mode, while straps govern.
// - Same source strap selects auxiliary group A..D.
// - Input termination held on under straps.
// - Pulse-on-source termination disabled for all sources.
// - One equalization strap drives every input.
// - Equalization strap 0 is 6 dB, 1 is 12 dB.
// - Pre-emphasis strap 00..11 gives 0,2,4,6 dB.
// - Output termination strap 0 off, 1 on.
// - Current strap 0 is 10 mA, 1 is 20 mA.
// - Straps govern until first serial access.
//
// Purpose: Turns strap pins into effective switch settings.
// Assumes: A serial register engine outside drives the register port.
// Notes:   The serial path takes over on its first access and keeps it.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module pin_strap_switch_config
  import strap_cfg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       strap_channel_enable,
  input  wire logic [1:0] strap_source_select,
  input  wire logic       strap_input_eq_level,
  input  wire logic [1:0] strap_preemph_level,
  input  wire logic       strap_out_term_on,
  input  wire logic       strap_out_current_level,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            hs_enable,
  output logic      [1:0] hs_mode,
  output logic      [3:0] hs_source_onehot,
  output logic            aux_enable,
  output logic      [1:0] aux_mode,
  output logic      [3:0] aux_common_out,
  output logic            in_term_on,
  output logic      [3:0] term_pulse_en,
  output logic      [7:0] eq_high,
  output logic      [1:0] preemph_level,
  output logic            out_term_on,
  output logic            out_current_high,
  output logic            serial_in_control
);
  import strap_cfg_pkg::*;

  function automatic logic [3:0] src_decode(input logic [1:0] sel);
    src_decode = 4'h1 << sel;
  endfunction

  logic [7:0] strap_sync_w;
  logic [7:0] mem_rdata;
  cfg_src_type src_r;
  cfg_src_type src_nxt;
  logic [7:0] img_r [NUM_REGS];
  logic [7:0] img_nxt [NUM_REGS];
  logic [7:0] strap_img [NUM_REGS];
  logic [7:0] eff [NUM_REGS];
  logic       serial_access;

  // Straps are asynchronous levels, so they are synchronised first.
  strap_sync #(.WIDTH(8)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({strap_channel_enable, strap_source_select,
                strap_input_eq_level, strap_preemph_level,
                strap_out_term_on, strap_out_current_level}),
    .sync_out (strap_sync_w)
  );

  wire       s_en   = strap_sync_w[7];
  wire [1:0] s_ch   = strap_sync_w[6:5];
  wire       s_eq   = strap_sync_w[4];
  wire [1:0] s_pe   = strap_sync_w[3:2];
  wire       s_oto  = strap_sync_w[1];
  wire       s_ocl  = strap_sync_w[0];

  // The strap image mirrors the parallel register map bit for bit.
  assign strap_img[OFF_HS_MODES]  = {1'b0, s_en, MODE_QUAD, 2'b00, s_ch};
  assign strap_img[OFF_AUX_MODES] = {RST_AUX_MODES[7:2], s_ch};
  assign strap_img[OFF_RX_SET]    = RST_RX_SET;
  assign strap_img[OFF_TERM_PUL1] = RST_TERM_PUL;
  assign strap_img[OFF_TERM_PUL2] = RST_TERM_PUL;
  assign strap_img[OFF_EQ1]       = {8{s_eq}};
  assign strap_img[OFF_EQ2]       = {8{s_eq}};
  assign strap_img[OFF_TX_SET]    = {4'h0, s_pe, s_oto, s_ocl};

  assign serial_access = reg_write | reg_read;
  assign src_nxt = (serial_access || src_r == SRC_SERIAL) ?
                   SRC_SERIAL : SRC_STRAP;

  // On the handover the serial image starts from the strap values, so
  // the outputs do not jump on a read-only first access.
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      img_nxt[i] = (src_r == SRC_STRAP) ? strap_img[i] : img_r[i];
      if (reg_write && reg_addr == i[2:0]) begin
        img_nxt[i] = reg_wdata;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      eff[i] = (src_nxt == SRC_STRAP) ? strap_img[i] : img_nxt[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      src_r       <= SRC_STRAP;
    end else begin
      src_r       <= src_nxt;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (!rst_n) begin
        img_r[i] <= 8'h00;
      end else begin
        img_r[i] <= img_nxt[i];
      end
    end
  end

  // This memory copy sees only register writes; read data come from the image below.
  cfg_image_mem #(.DEPTH(NUM_REGS), .AW(3)) u_mem (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (reg_write),
    .wr_addr (reg_addr),
    .wr_data (reg_wdata),
    .rd_addr (reg_addr),
    .rd_data (mem_rdata)
  );

  // Read data stand one cycle and fall back to zero, straight from a flop.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= (src_r == SRC_STRAP) ? strap_img[reg_addr]
                                        : img_r[reg_addr];
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  // The memory is kept for a read path; the image is authoritative.
  wire [7:0] unused_rd = mem_rdata;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hs_enable         <= 1'b0;
      hs_mode           <= MODE_QUAD;
      hs_source_onehot  <= 4'h0;
      aux_enable        <= 1'b1;
      aux_mode          <= MODE_QUAD;
      aux_common_out    <= 4'h0;
      in_term_on        <= 1'b1;
      term_pulse_en     <= 4'h0;
      eq_high           <= 8'h00;
      preemph_level     <= 2'h0;
      out_term_on       <= 1'b0;
      out_current_high  <= 1'b0;
      serial_in_control <= 1'b0;
    end else begin
      hs_enable        <= eff[OFF_HS_MODES][POS_SW_ENABLE];
      hs_mode          <= eff[OFF_HS_MODES][5:4];
      hs_source_onehot <= src_decode(eff[OFF_HS_MODES][1:0]);
      aux_enable       <= eff[OFF_AUX_MODES][POS_SW_ENABLE];
      aux_mode         <= eff[OFF_AUX_MODES][5:4];
      aux_common_out   <= src_decode(eff[OFF_AUX_MODES][1:0]);
      in_term_on       <= eff[OFF_RX_SET][0];
      term_pulse_en    <= {|eff[OFF_TERM_PUL2][7:4], |eff[OFF_TERM_PUL2][3:0],
                           |eff[OFF_TERM_PUL1][7:4],
                           |eff[OFF_TERM_PUL1][3:0]};
      eq_high          <= {eff[OFF_EQ2][7:4], eff[OFF_EQ1][3:0]};
      preemph_level    <= eff[OFF_TX_SET][3:2];
      out_term_on      <= eff[OFF_TX_SET][POS_OTO];
      out_current_high <= eff[OFF_TX_SET][POS_OCL];
      serial_in_control <= (src_nxt == SRC_SERIAL);
    end
  end

  a_strap_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (src_r == SRC_STRAP && !serial_access) |=> hs_enable == $past(s_en))
    else $error("enable does not follow strap");
  a_quad_mode: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control |-> hs_mode == MODE_QUAD && aux_mode == MODE_QUAD)
    else $error("mode not quad under straps");
  a_aux_on: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control |-> aux_enable)
    else $error("aux disabled under straps");
  a_src_route: assert property (@(posedge clock) disable iff (!rst_n)
    (src_r == SRC_STRAP && !serial_access) |=>
    hs_source_onehot == (4'h1 << $past(s_ch)) &&
    aux_common_out == hs_source_onehot)
    else $error("source routing wrong");
  a_term_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control |-> in_term_on && term_pulse_en == 4'h0)
    else $error("input termination wrong");
  a_eq_all: assert property (@(posedge clock) disable iff (!rst_n)
    (src_r == SRC_STRAP && !serial_access) |=> eq_high == {8{$past(s_eq)}})
    else $error("equalization not common");
  a_tx_set: assert property (@(posedge clock) disable iff (!rst_n)
    (src_r == SRC_STRAP && !serial_access) |=>
    {preemph_level, out_term_on, out_current_high} ==
    $past({s_pe, s_oto, s_ocl}))
    else $error("transmitter settings wrong");
  a_handover: assert property (@(posedge clock) disable iff (!rst_n)
    serial_access |=> serial_in_control [*3])
    else $error("strap path regained control");
  c_serial_take: cover property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control ##1 serial_in_control);
  c_source_d: cover property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control && hs_source_onehot == 4'h8);
  c_strap_change: cover property (@(posedge clock) disable iff (!rst_n)
    !serial_in_control && $changed(preemph_level));
endmodule

// ==== strap_board.sv ====
// Purpose: Board model that ties each strap input to a static rail.
// Assumes: The bench picks the rail of each strap through a config word.
// Notes:   A strap is never left floating, so no unknown reaches the pins.
`timescale 1ns/1ps
module strap_board (
  input  wire logic [7:0] cfg,
  output logic            channel_enable,
  output logic      [1:0] source_select,
  output logic            input_eq_level,
  output logic      [1:0] preemph_level,
  output logic            out_term_on,
  output logic            out_current_level
);
  // Each pin is a plain rail, logic 1 or logic 0, held until the bench moves it.
  assign channel_enable    = cfg[0];
  assign source_select     = cfg[2:1];
  assign input_eq_level    = cfg[3];
  assign preemph_level     = cfg[5:4];
  assign out_term_on       = cfg[6];
  assign out_current_level = cfg[7];
endmodule

// ==== tb_pin_strap_switch_config.sv ====
// Purpose: Self-checking bench for the strap configuration loader.
// Assumes: Straps settle within four edges of a change.
// Notes:   Sweeps all 256 strap words, then hands over to the register port.
`timescale 1ns/1ps
module tb_pin_strap_switch_config;
  import strap_cfg_pkg::*;
  logic       clock;
  logic       rst_n;
  logic [7:0] board_cfg;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  wire        s_en, s_eq, s_oto, s_ocl;
  wire  [1:0] s_src, s_pe;
  wire  [7:0] reg_rdata, eq_high;
  wire        hs_enable, aux_enable, in_term_on, out_term_on;
  wire        out_current_high, serial_in_control;
  wire  [1:0] hs_mode, aux_mode, preemph_level;
  wire  [3:0] hs_source_onehot, aux_common_out, term_pulse_en;
  int         fails;
  int         samples_checked;

  strap_board u_board (.cfg(board_cfg), .channel_enable(s_en),
    .source_select(s_src), .input_eq_level(s_eq), .preemph_level(s_pe),
    .out_term_on(s_oto), .out_current_level(s_ocl));

  pin_strap_switch_config u_dut (.clock(clock), .rst_n(rst_n),
    .strap_channel_enable(s_en), .strap_source_select(s_src),
    .strap_input_eq_level(s_eq), .strap_preemph_level(s_pe),
    .strap_out_term_on(s_oto), .strap_out_current_level(s_ocl),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .hs_enable(hs_enable),
    .hs_mode(hs_mode), .hs_source_onehot(hs_source_onehot),
    .aux_enable(aux_enable), .aux_mode(aux_mode),
    .aux_common_out(aux_common_out), .in_term_on(in_term_on),
    .term_pulse_en(term_pulse_en), .eq_high(eq_high),
    .preemph_level(preemph_level), .out_term_on(out_term_on),
    .out_current_high(out_current_high),
    .serial_in_control(serial_in_control));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there.
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check_straps(input logic [7:0] c);
    chk({7'h00, hs_enable}, {7'h00, c[0]});
    chk({6'h00, hs_mode}, {6'h00, MODE_QUAD});
    chk({4'h0, hs_source_onehot}, 8'h01 << c[2:1]);
    chk({7'h00, aux_enable}, 8'h01);
    chk({6'h00, aux_mode}, {6'h00, MODE_QUAD});
    chk({4'h0, aux_common_out}, 8'h01 << c[2:1]);
    chk({7'h00, in_term_on}, 8'h01);
    chk({4'h0, term_pulse_en}, 8'h00);
    chk(eq_high, {8{c[3]}});
    chk({6'h00, preemph_level}, {6'h00, c[5:4]});
    chk({7'h00, out_term_on}, {7'h00, c[6]});
    chk({7'h00, out_current_high}, {7'h00, c[7]});
    chk({7'h00, serial_in_control}, 8'h00);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    close_out();
  end

  initial begin
    logic [7:0] rd;
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    board_cfg = 8'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge clock);
      board_cfg <= i[7:0];
      repeat (4) @(posedge clock);
      #1;
      check_straps(i[7:0]);
    end
    $display("test strap sweep done");
    reg_wr(OFF_TX_SET, 8'h0e);
    repeat (2) @(posedge clock);
    #1;
    chk({7'h00, serial_in_control}, 8'h01);
    chk({6'h00, preemph_level}, 8'h03);
    chk({7'h00, out_current_high}, 8'h00);
    @(posedge clock);
    board_cfg <= 8'h00;
    repeat (4) @(posedge clock);
    #1;
    chk({7'h00, hs_enable}, 8'h01);
    chk({4'h0, hs_source_onehot}, 8'h08);
    reg_rd(OFF_TX_SET, rd);
    chk(rd, 8'h0e);
    reg_rd(OFF_HS_MODES, rd);
    chk(rd, 8'h43);
    $display("test serial takeover done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check_straps(8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
